// >>> rtl/swi_map.svh
// register offsets, field positions and reset values of the port interrupt block
`ifndef SWI_MAP_SVH
`define SWI_MAP_SVH

`define SWI_OFF_CMD       12'h004
`define SWI_OFF_MSI_CTL   12'h048
`define SWI_OFF_MSI_ADDLO 12'h04C
`define SWI_OFF_MSI_ADDHI 12'h050
`define SWI_OFF_MSI_DATA  12'h054
`define SWI_OFF_MSI_MASK  12'h058
`define SWI_OFF_PIN_CTL   12'h1C8
`define SWI_OFF_EV_FLAG   12'h1D0
`define SWI_OFF_EV_MASK   12'h1D4
`define SWI_OFF_STATE     12'h1D8

`define SWI_BIT_INT_DIS   10
`define SWI_BIT_INT_STS   19
`define SWI_BIT_MSI_EN    16
`define SWI_BIT_MSI_64    23
`define SWI_BIT_PIN_EN    4
`define SWI_BIT_MSI_MASK  0

`define SWI_MSI_CAP_ID    8'h05
`define SWI_MSI_NEXT_PTR  8'h00
`define SWI_EV_MASK_RST   8'h00
`define SWI_EV_HP_COUNT   6

`endif

// >>> rtl/swi_pkg.sv
// types shared by the port interrupt block and its surroundings
package swi_pkg;

  localparam int SWI_NUM_EV = 8;

  typedef enum logic [1:0] {
    SWI_INTA,
    SWI_INTB,
    SWI_INTC,
    SWI_INTD
  } swi_intx_t;

  // one assert or deassert interrupt message
  typedef struct packed {
    logic      valid;
    logic      raise;
    swi_intx_t kind;
  } swi_msg_t;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } swi_wb_req_t;

  // single dword memory write carrying an msi
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
    logic [31:0] data;
  } swi_msi_wr_t;

endpackage

// >>> rtl/swi_top.sv
// per-port interrupt generation and upstream intx collapsing
//
// Notes on behaviour
// - Eight event inputs: five hot-plug, link state, ram ecc, error queue overflow.
// - Pin enable steers hot-plug/link events to the pin instead of INTA messages.
// - With pin enable set, error interrupts drive the pin in step with the internal INTA level.
// - Locally generated messages are always INTA; forwarded ones may be any type.
// - A request sets interrupt status; INTx enabled sends Assert_INTA upstream.
// - Each event has its own mask; only unmasked events raise a request.
// - Messages from downstream devices are forwarded, never regenerated locally.
// - Upstream remaps type by device number: rotate by zero, one, two or three.
// - Remapped sources OR into four levels; edges become assert/deassert messages.
// - MSI and INTx are never active together; MSI enable masks INTx even with interrupt disable 0.
// - An MSI capability with identifier 05h is presented.
// - Multiple message enable and capable fields always read zero.
// - The 64-bit address capable bit reads one.
// - With MSI on, an event writes one dword: low data half, upper zero.
// - After one MSI no new one until the mask bit is serviced.
// - Pin active only with interrupt disable 0, MSI off and pin enable 1.
// - With MSI enabled no pin activity and no INTx messages for local events.
// - Forwarding of downstream INTx is always enabled.
// - Local interrupt start and end send Assert_INTA / Deassert_INTA upstream.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "swi_map.svh"

module swi_top #(
  parameter int                NUM_DS    = 8,
  parameter logic [NUM_DS*4-1:0] DS_DEVNUM = 32'h8765_4321
) (
  // clock and reset
  input  wire logic                             mclk_in,
  input  wire logic                             rst_n_in,
  // register bus
  input  wire swi_pkg::swi_wb_req_t             wb_req_in,
  output logic [31:0]                           wb_dat_out,
  output logic                                  wb_ack_out,
  // interrupt events, one-cycle pulses
  input  wire logic [swi_pkg::SWI_NUM_EV-1:0]   event_in,
  // messages arriving from downstream ports
  input  wire swi_pkg::swi_msg_t [NUM_DS-1:0]   ds_fwd_msg_in,
  input  wire swi_pkg::swi_msg_t [NUM_DS-1:0]   ds_int_msg_in,
  // local message toward the upstream port
  output swi_pkg::swi_msg_t                     loc_msg_out,
  // collapsed messages toward the host
  output swi_pkg::swi_msg_t                     up_msg_out,
  // msi memory write
  output swi_pkg::swi_msi_wr_t                  msi_wr_out,
  input  wire logic                             msi_ready_in,
  // interrupt pin
  output logic                                  interrupt_pin_n_out
);
  import swi_pkg::*;

  localparam int EV = SWI_NUM_EV;
  localparam int HP = `SWI_EV_HP_COUNT;

  typedef struct packed {
    logic [EV-1:0]       flags;
    logic [EV-1:0]       evmask;
    logic                int_disable;
    logic                int_status;
    logic                msi_en;
    logic [63:0]         msi_addr;
    logic [15:0]         msi_data;
    logic                msi_mask;
    logic                mask_prev;
    logic                pin_en;
    logic                pin_act;
    logic                intx_prev;
    logic                req_prev;
    logic                msi_pend;
    logic                msi_block;
    logic                msi_valid;
    swi_msg_t            loc_msg;
    logic [NUM_DS*4-1:0] fwd_lvl;
    logic [NUM_DS*4-1:0] dsi_lvl;
    logic [3:0]          up_sent;
    swi_msg_t            up_msg;
    logic                ack;
    logic [31:0]         rdat;
  } swi_state_t;

  swi_state_t st;
  swi_state_t next_st;

  // byte lanes to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  // type rotation by device number
  function automatic swi_intx_t remap(input logic [1:0] kind, input logic [3:0] dev);
    return swi_intx_t'(2'(kind + dev[1:0]));
  endfunction

  function automatic logic [31:0] read_reg(input logic [11:0] adr, input swi_state_t s);
    logic [31:0] r;
    r = '0;
    case (adr)
      `SWI_OFF_CMD: begin
        r[`SWI_BIT_INT_DIS] = s.int_disable;
        r[`SWI_BIT_INT_STS] = s.int_status;
      end
      `SWI_OFF_MSI_CTL: begin
        r[7:0]              = `SWI_MSI_CAP_ID;
        r[15:8]             = `SWI_MSI_NEXT_PTR;
        r[`SWI_BIT_MSI_EN]  = s.msi_en;
        r[`SWI_BIT_MSI_64]  = 1'b1;
      end
      `SWI_OFF_MSI_ADDLO: r = {s.msi_addr[31:2], 2'b00};
      `SWI_OFF_MSI_ADDHI: r = s.msi_addr[63:32];
      `SWI_OFF_MSI_DATA:  r = {16'h0000, s.msi_data};
      `SWI_OFF_MSI_MASK:  r[`SWI_BIT_MSI_MASK] = s.msi_mask;
      `SWI_OFF_PIN_CTL:   r[`SWI_BIT_PIN_EN] = s.pin_en;
      `SWI_OFF_EV_FLAG:   r[EV-1:0] = s.flags;
      `SWI_OFF_EV_MASK:   r[EV-1:0] = s.evmask;
      `SWI_OFF_STATE:     r[9:0] = {s.up_sent, s.pin_act, s.intx_prev,
                                    s.msi_valid, s.msi_block, s.msi_pend, s.int_status};
      default:            r = '0;
    endcase
    return r;
  endfunction

  logic          hp_req;
  logic          err_req;
  logic          any_req;
  logic          intx_en;
  logic          intx_lvl;
  logic          wr_go;
  logic [31:0]   wm;
  logic [31:0]   wd;
  logic [3:0]    agg;

  always_comb begin
    logic found;
    logic [3:0] dev;
    found   = 1'b0;
    dev     = '0;
    next_st = st;
    next_st.ack          = 1'b0;
    next_st.loc_msg.valid = 1'b0;
    next_st.up_msg.valid  = 1'b0;

    // masked requests
    hp_req  = |(st.flags[HP-1:0] & ~st.evmask[HP-1:0]);
    err_req = |(st.flags[EV-1:HP] & ~st.evmask[EV-1:HP]);
    any_req = hp_req | err_req;
    intx_en = ~st.int_disable & ~st.msi_en;
    intx_lvl = intx_en & (err_req | (hp_req & ~st.pin_en));

    // bus slave: ack one cycle after the request, write on the acked edge
    wr_go = wb_req_in.cyc & wb_req_in.stb & wb_req_in.we & st.ack;
    wm    = lane_mask(wb_req_in.sel);
    wd    = wb_req_in.dat & wm;
    if (wb_req_in.cyc && wb_req_in.stb && !st.ack) begin
      next_st.ack  = 1'b1;
      next_st.rdat = read_reg(wb_req_in.adr, st);
    end

    // sticky flags, set beats clear
    next_st.flags      = st.flags | event_in;
    next_st.int_status = st.int_status | any_req;
    if (wr_go) begin
      case (wb_req_in.adr)
        `SWI_OFF_CMD: begin
          if (wm[`SWI_BIT_INT_DIS]) next_st.int_disable = wd[`SWI_BIT_INT_DIS];
          if (wd[`SWI_BIT_INT_STS]) next_st.int_status = any_req;
        end
        `SWI_OFF_MSI_CTL:
          if (wm[`SWI_BIT_MSI_EN]) next_st.msi_en = wd[`SWI_BIT_MSI_EN];
        `SWI_OFF_MSI_ADDLO: next_st.msi_addr[31:0] = (st.msi_addr[31:0] & ~wm) | wd;
        `SWI_OFF_MSI_ADDHI: next_st.msi_addr[63:32] = (st.msi_addr[63:32] & ~wm) | wd;
        `SWI_OFF_MSI_DATA:
          next_st.msi_data = (st.msi_data & ~wm[15:0]) | wd[15:0];
        `SWI_OFF_MSI_MASK:
          if (wm[`SWI_BIT_MSI_MASK]) next_st.msi_mask = wd[`SWI_BIT_MSI_MASK];
        `SWI_OFF_PIN_CTL:
          if (wm[`SWI_BIT_PIN_EN]) next_st.pin_en = wd[`SWI_BIT_PIN_EN];
        `SWI_OFF_EV_FLAG:
          next_st.flags = (st.flags & ~wd[EV-1:0]) | event_in;
        `SWI_OFF_EV_MASK:
          next_st.evmask = (st.evmask & ~wm[EV-1:0]) | wd[EV-1:0];
        default: begin
        end
      endcase
    end

    // pin and local INTA message
    next_st.pin_act = intx_en & st.pin_en & (hp_req | err_req);
    if (intx_lvl != st.intx_prev) begin
      next_st.intx_prev     = intx_lvl;
      next_st.loc_msg.valid = 1'b1;
      next_st.loc_msg.raise = intx_lvl;
      next_st.loc_msg.kind  = SWI_INTA;
    end

    // msi: edge of the request, one write, then wait for mask service
    next_st.req_prev  = any_req;
    next_st.mask_prev = st.msi_mask;
    if (!st.msi_en) begin
      next_st.msi_pend = 1'b0;
    end else if (any_req && !st.req_prev) begin
      next_st.msi_pend = 1'b1;
    end
    if (st.msi_mask && !st.mask_prev) begin
      next_st.msi_block = 1'b0;
    end
    if (st.msi_valid) begin
      if (msi_ready_in) begin
        next_st.msi_valid = 1'b0;
        next_st.msi_block = 1'b1;
      end
    end else if (st.msi_pend && !st.msi_block && !st.msi_mask && st.msi_en) begin
      next_st.msi_valid = 1'b1;
      next_st.msi_pend  = 1'b0;
    end

    // downstream levels, always tracked
    for (int i = 0; i < NUM_DS; i++) begin
      if (ds_fwd_msg_in[i].valid) begin
        next_st.fwd_lvl[i*4 + int'(ds_fwd_msg_in[i].kind)] = ds_fwd_msg_in[i].raise;
      end
      if (ds_int_msg_in[i].valid) begin
        next_st.dsi_lvl[i*4] = ds_int_msg_in[i].raise;
      end
    end

    // collapse into four levels
    agg = '0;
    agg[0] = st.intx_prev;
    for (int i = 0; i < NUM_DS; i++) begin
      dev = DS_DEVNUM[i*4 +: 4];
      for (int k = 0; k < 4; k++) begin
        if (st.fwd_lvl[i*4+k] || st.dsi_lvl[i*4+k]) begin
          agg[remap(2'(k), dev)] = 1'b1;
        end
      end
    end

    // one message per cycle, lowest type first
    for (int j = 0; j < 4; j++) begin
      if (!found && agg[j] != st.up_sent[j]) begin
        found                = 1'b1;
        next_st.up_sent[j]   = agg[j];
        next_st.up_msg.valid = 1'b1;
        next_st.up_msg.raise = agg[j];
        next_st.up_msg.kind  = swi_intx_t'(2'(j));
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st        <= '0;
      st.evmask <= `SWI_EV_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_out          = st.rdat;
  assign wb_ack_out          = st.ack;
  assign loc_msg_out         = st.loc_msg;
  assign up_msg_out          = st.up_msg;
  assign msi_wr_out.valid    = st.msi_valid;
  assign msi_wr_out.addr     = {st.msi_addr[63:2], 2'b00};
  assign msi_wr_out.data     = {16'h0000, st.msi_data};
  assign interrupt_pin_n_out = ~st.pin_act;

endmodule

// >>> dv/swi_top_properties.sv
// port-level assertions for the interrupt block
`timescale 1ns/1ps
module swi_top_properties (
  // clock and reset
  input wire logic                 mclk_in,
  input wire logic                 rst_n_in,
  // bus
  input wire swi_pkg::swi_wb_req_t wb_req_in,
  input wire logic                 wb_ack_out,
  // interrupt outputs
  input wire swi_pkg::swi_msg_t    loc_msg_out,
  input wire swi_pkg::swi_msi_wr_t msi_wr_out,
  input wire logic                 msi_ready_in,
  input wire logic                 interrupt_pin_n_out
);
  import swi_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req;
    wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  endsequence
  sequence s_msi_wait;
    msi_wr_out.valid && !msi_ready_in;
  endsequence
  sequence s_msi_take;
    msi_wr_out.valid && msi_ready_in;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_out)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  a_local_inta: assert property (loc_msg_out.valid |-> loc_msg_out.kind == SWI_INTA)
    else $error("local kind");
  a_msi_holds: assert property (s_msi_wait |=> msi_wr_out.valid && $stable(msi_wr_out))
    else $error("msi dropped");
  a_msi_shape: assert property (msi_wr_out.valid |-> !(|msi_wr_out.data[31:16]))
    else $error("msi data");
  a_msi_no_pin: assert property (msi_wr_out.valid |-> interrupt_pin_n_out)
    else $error("pin with msi");
  a_msi_no_intx: assert property (msi_wr_out.valid |-> !loc_msg_out.valid)
    else $error("intx with msi");
  a_msi_one: assert property (s_msi_take |=> (!msi_wr_out.valid) [*2])
    else $error("msi repeat");
endmodule
bind swi_top swi_top_properties i_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out), .loc_msg_out(loc_msg_out),
  .msi_wr_out(msi_wr_out), .msi_ready_in(msi_ready_in),
  .interrupt_pin_n_out(interrupt_pin_n_out));

// >>> dv/swi_host_model.sv
// msi completer standing for the host
`timescale 1ns/1ps
module swi_host_model (
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  // msi write port
  input  wire swi_pkg::swi_msi_wr_t msi_wr_in,
  input  wire logic                 slow_in,
  output logic                      msi_ready_out,
  // last accepted write
  output swi_pkg::swi_msi_wr_t      got_out,
  output logic [7:0]                got_cnt_out
);
  import swi_pkg::*;
  logic [1:0] wt;
  // slow mode stalls three cycles
  assign msi_ready_out = msi_wr_in.valid && (!slow_in || wt == 2'h3);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wt <= 2'h0;
      got_cnt_out <= 8'h00;
      got_out <= '0;
    end else if (msi_ready_out) begin
      wt <= 2'h0;
      got_cnt_out <= got_cnt_out + 8'h01;
      got_out <= msi_wr_in;
    end else if (msi_wr_in.valid) begin
      wt <= wt + 2'h1;
    end
  end
endmodule

// >>> dv/tb_switch_port_interrupt_generation.sv
// testbench for the port interrupt block
`timescale 1ns/1ps
module tb_switch_port_interrupt_generation;
  import swi_pkg::*;
  logic clk, rst_n, wb_ack, pin, rdy, slow;
  logic [31:0] wb_dat, q, a, d, rnd;
  logic [7:0] ev, gc;
  logic [1:0] k;
  swi_wb_req_t wb_req;
  swi_msg_t [7:0] dsf, dsi;
  swi_msg_t loc, up, loc_last, up_last;
  swi_msi_wr_t msi, got;
  int mismatches, compares, cyc, loc_n, up_n, n, i, j;
  swi_top i_dut (.mclk_in(clk), .rst_n_in(rst_n), .wb_req_in(wb_req), .wb_dat_out(wb_dat),
    .wb_ack_out(wb_ack), .event_in(ev), .ds_fwd_msg_in(dsf), .ds_int_msg_in(dsi),
    .loc_msg_out(loc), .up_msg_out(up), .msi_wr_out(msi), .msi_ready_in(rdy),
    .interrupt_pin_n_out(pin));
  swi_host_model i_host (.mclk_in(clk), .rst_n_in(rst_n), .msi_wr_in(msi), .slow_in(slow),
    .msi_ready_out(rdy), .got_out(got), .got_cnt_out(gc));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [11:0] ad, input logic [31:0] dt);
    wb_req <= '{1'h1, 1'h1, we, ad, 4'hF, dt};
    @(posedge clk);
    while (wb_ack !== 1'h1) @(posedge clk);
    q = wb_dat;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [7:0] b);
    ev <= b;
    @(posedge clk);
    ev <= 8'h00;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (loc.valid === 1'h1) begin
      loc_n++;
      loc_last = loc;
    end
    if (up.valid === 1'h1) begin
      up_n++;
      up_last = up;
    end
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    {wb_req, ev, dsf, dsi, slow, rst_n} = '0;
    rnd = 32'h82D76C54;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    wb(1'h1, 12'h048, 32'hFFFEFFFF);
    wb(1'h0, 12'h048, 32'h0);
    chk("msi_ctl", q, 32'h00800005);
    wb(1'h0, 12'h100, 32'h0);
    chk("unmapped", q, 32'h0);
    n = loc_n;
    pulse(8'h40);
    chk("loc_n", loc_n, n + 1);
    chk("loc", loc_last, {1'h1, 1'h1, SWI_INTA});
    chk("up", up_last, {1'h1, 1'h1, SWI_INTA});
    chk("pin_off", pin, 1'h1);
    wb(1'h0, 12'h004, 32'h0);
    chk("int_sts", q[19], 1'h1);
    wb(1'h1, 12'h1D0, 32'hFF);
    wb(1'h1, 12'h004, 32'h00080000);
    repeat (6) @(posedge clk);
    chk("loc_end", loc_last.raise, 1'h0);
    chk("up_end", up_last.raise, 1'h0);
    wb(1'h1, 12'h1D4, 32'h01);
    n = loc_n;
    pulse(8'h01);
    chk("masked", loc_n, n);
    wb(1'h1, 12'h1C8, 32'h10);
    pulse(8'h20);
    chk("pin_low", pin, 1'h0);
    chk("no_msg", loc_n, n);
    wb(1'h1, 12'h004, 32'h400);
    repeat (2) @(posedge clk);
    chk("pin_dis", pin, 1'h1);
    wb(1'h1, 12'h1D0, 32'hFF);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      k = i[0] ? 2'h0 : rnd[1:0];
      for (j = 0; j < 2; j++) begin
        n = up_n;
        if (i[0]) dsi[i] <= '{1'h1, ~j[0], SWI_INTA};
        else dsf[i] <= '{1'h1, ~j[0], swi_intx_t'(k)};
        @(posedge clk);
        dsf <= '0;
        dsi <= '0;
        repeat (5) @(posedge clk);
        chk("up_n", up_n, n + 1);
        chk("up_fwd", up_last, {1'h1, ~j[0], 2'(k + i + 1)});
      end
    end
    wb(1'h1, 12'h004, 32'h0);
    rnd = lfsr(rnd);
    a = rnd;
    rnd = lfsr(rnd);
    d = rnd;
    wb(1'h1, 12'h04C, a);
    wb(1'h1, 12'h050, d);
    wb(1'h1, 12'h054, d);
    wb(1'h0, 12'h04C, 32'h0);
    chk("addr_lo", q, {a[31:2], 2'h0});
    wb(1'h0, 12'h054, 32'h0);
    chk("msi_data", q, {16'h0, d[15:0]});
    wb(1'h1, 12'h1D4, 32'h0);
    wb(1'h1, 12'h048, 32'h00010000);
    for (i = 0; i < 2; i++) begin
      slow <= i[0];
      n = gc;
      pulse(8'h80);
      if (i) begin
        chk("blocked", gc, n);
        wb(1'h1, 12'h058, 32'h1);
        wb(1'h1, 12'h058, 32'h0);
        repeat (8) @(posedge clk);
      end
      chk("msi_n", gc, n + 1);
      chk("msi_wr", got, {1'h1, d, a[31:2], 2'h0, 16'h0, d[15:0]});
      wb(1'h1, 12'h1D0, 32'hFF);
    end
    tally_and_finish;
  end
endmodule
